//--- core/bir_pkg.sv
// bir_pkg: constants shared by the board interrupt router files
// assumes: configuration accesses arrive on the system clock as byte-wide register cycles
package bir_pkg;

  // configuration offsets of the two route registers
  localparam logic [7:0] BIR_ROUTE0_OFS = 8'h70;
  localparam logic [7:0] BIR_ROUTE1_OFS = 8'h71;

  // value after reset: routing disabled, sharing off, pin used as board input
  localparam logic [7:0] BIR_ROUTE_RST  = 8'h80;

  // writable bits; bit 4 always reads zero, bit 5 exists only in route 0
  localparam logic [7:0] BIR_WMASK0     = 8'hEF;
  localparam logic [7:0] BIR_WMASK1     = 8'hCF;

  // field positions inside a route register
  localparam int BIR_DIS_BIT   = 7;
  localparam int BIR_SHARE_BIT = 6;
  localparam int BIR_TIMER_BIT = 5;
  localparam int BIR_RSVD_BIT  = 4;
  localparam int BIR_SEL_MSB   = 3;

  // controller input count and target selects that are reserved
  localparam int         BIR_NUM_IRQ = 16;
  localparam logic [3:0] BIR_SEL_R0  = 4'h0;
  localparam logic [3:0] BIR_SEL_R1  = 4'h1;
  localparam logic [3:0] BIR_SEL_R2  = 4'h2;
  localparam logic [3:0] BIR_SEL_R8  = 4'h8;
  localparam logic [3:0] BIR_SEL_R13 = 4'hD;

  // true when a target select names a real controller input
  function automatic logic bir_target_ok(input logic [3:0] sel);
    bir_target_ok = !(sel == BIR_SEL_R0 || sel == BIR_SEL_R1 || sel == BIR_SEL_R2 ||
                      sel == BIR_SEL_R8 || sel == BIR_SEL_R13);
  endfunction

endpackage

//--- core/bir_route_dec.sv
// bir_route_dec: decodes one route register into hit and mask vectors
// assumes: route value and board request are already in the system clock domain
`timescale 1ns/10ps
module bir_route_dec
  import bir_pkg::*;
(
  input  wire logic [7:0] route_i,  // route register contents
  input  wire logic       board_i,  // synchronised board request
  bir_route_if.drv        out       // hit and mask vectors
);
  import bir_pkg::*;

  wire       enabled_w = !route_i[BIR_DIS_BIT];                 // bit clear means route
  wire       valid_w   = bir_target_ok(route_i[BIR_SEL_MSB:0]); // reserved codes go nowhere
  wire       share_w   = route_i[BIR_SHARE_BIT];
  wire [3:0] sel_w     = route_i[BIR_SEL_MSB:0];

  // one slot per controller input; code value equals the input number
  genvar n;
  generate
    for (n = 0; n < BIR_NUM_IRQ; n++) begin : g_slot
      wire sel_hit_w = enabled_w && valid_w && (sel_w == 4'(n));
      assign out.hit[n]  = sel_hit_w && board_i;
      assign out.mask[n] = sel_hit_w && !share_w;
    end
  endgenerate

endmodule

//--- core/bir_route_if.sv
// bir_route_if: per-route hit and mask vectors from a decoder to the router
// assumes: both ends run on the system clock
`timescale 1ns/10ps
interface bir_route_if;
  logic [15:0] hit;   // board request lands on this controller input
  logic [15:0] mask;  // expansion-bus request on this input is blocked

  modport drv (output hit, output mask);
  modport snk (input hit, input mask);  // use is a reserved word, hence snk
endinterface

//--- core/bir_router.sv
// bir_router: steers two board interrupt requests onto legacy controller inputs
// assumes: config cycles are single-cycle strobes on clk_sys_i; irq pins are asynchronous
// Behaviour
// - each board input steers independently, eleven targets
// - bit 7 clear routes to field 3:0
// - code equals irq number; 0,1,2,8,13 reserved
// - sharing clear masks the selected expansion-bus irq
// - route0 bit 5 makes shared pin timer output
// - disk flag source follows bit 5 option
// - bit 4 of both registers reads zero
`timescale 1ns/10ps
module bir_router
  import bir_pkg::*;
(
  input  wire logic        clk_sys_i,        // system clock, 250 MHz
  input  wire logic        reset_i,          // async reset, active high
  input  wire logic [7:0]  cfg_addr_i,       // configuration offset
  input  wire logic        cfg_wr_i,         // write strobe, one cycle
  input  wire logic        cfg_rd_i,         // read strobe, one cycle
  input  wire logic [7:0]  cfg_wdata_i,      // write data
  output logic      [7:0]  cfg_rdata_o,      // read data, valid the cycle after rd
  input  wire logic        shared_timer_irq_pin_i,  // shared pin level (board input 0)
  output logic             shared_timer_irq_pin_o,  // timer level driven onto pin
  output logic             shared_timer_irq_pin_oe_o, // high while driving the pin
  input  wire logic        board_irq_in_i,   // board input 1 pin
  input  wire logic [15:0] isa_irq_i,        // expansion-bus irq lines
  input  wire logic        timer_irq_i,      // timer request, same clock
  output logic      [15:0] ctrl_irq_o,       // requests to the controller pair
  output logic             disk_irq_flag_o   // source for disk interrupt status flag
);
  import bir_pkg::*;

  logic [7:0]  route0_q;
  logic [7:0]  route1_q;
  logic [17:0] sync1_q;
  logic [17:0] sync2_q;

  // two-stage synchroniser: {pin, board1, isa[15:0]}; only stage 2 is read
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {shared_timer_irq_pin_i, board_irq_in_i, isa_irq_i};
      sync2_q <= sync1_q;
    end
  end

  wire [15:0] isa_s      = sync2_q[15:0];
  wire        board1_s   = sync2_q[16];
  wire        pin_s      = sync2_q[17];
  wire        timer_on_w = route0_q[BIR_TIMER_BIT];
  // when the pin is an output its own level must not route back in
  wire        board0_s   = pin_s && !timer_on_w;

  // register decode
  wire wr0_w = cfg_wr_i && (cfg_addr_i == BIR_ROUTE0_OFS);
  wire wr1_w = cfg_wr_i && (cfg_addr_i == BIR_ROUTE1_OFS);
  wire [7:0] rd_mux_w = (cfg_addr_i == BIR_ROUTE0_OFS) ? route0_q :
                        (cfg_addr_i == BIR_ROUTE1_OFS) ? route1_q : 8'h00;

  // route registers; reserved bits are never stored so they always read zero
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      route0_q <= BIR_ROUTE_RST;
      route1_q <= BIR_ROUTE_RST;
    end else begin
      if (wr0_w) route0_q <= cfg_wdata_i & BIR_WMASK0;
      if (wr1_w) route1_q <= cfg_wdata_i & BIR_WMASK1;
    end
  end

  // read port; unmapped offsets answer zero
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) cfg_rdata_o <= 8'h00;
    else if (cfg_rd_i) cfg_rdata_o <= rd_mux_w;
  end

  // one decoder per route register
  bir_route_if r0_if ();
  bir_route_if r1_if ();

  bir_route_dec u_dec0 (
    .route_i (route0_q),
    .board_i (board0_s),
    .out     (r0_if.drv)
  );

  bir_route_dec u_dec1 (
    .route_i (route1_q),
    .board_i (board1_s),
    .out     (r1_if.drv)
  );

  // masked bus lines plus board hits; sharing simply ors them, which is why
  // both sources must be active-high levels
  wire [15:0] irq_d = (isa_s & ~(r0_if.mask | r1_if.mask))
                    | r0_if.hit | r1_if.hit;
  // disk flag follows irq15 when the pin has become the timer output
  wire        disk_d = timer_on_w ? isa_s[15] : board0_s;

  // registered outputs
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_irq_o                <= '0;
      disk_irq_flag_o           <= 1'b0;
      shared_timer_irq_pin_o    <= 1'b0;
      shared_timer_irq_pin_oe_o <= 1'b0;
    end else begin
      ctrl_irq_o                <= irq_d;
      disk_irq_flag_o           <= disk_d;
      shared_timer_irq_pin_o    <= timer_irq_i && timer_on_w;
      shared_timer_irq_pin_oe_o <= timer_on_w;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  rsvd_read_a: assert property (cfg_rd_i |=> !cfg_rdata_o[BIR_RSVD_BIT])
    else $error("reserved bit 4 read back nonzero");

  route_write_a: assert property (wr0_w |=> route0_q == ($past(cfg_wdata_i) & BIR_WMASK0))
    else $error("route 0 write not stored");

  route_dis_a: assert property ((route0_q[7] && route1_q[7]) |=> ctrl_irq_o == $past(isa_s))
    else $error("disabled route changed controller inputs");

  route_hit_a: assert property ((!route1_q[7] && route1_q[3:0] == 4'h5 && board1_s)
                                |=> ctrl_irq_o[5])
    else $error("board input 1 not routed to irq5");

  rsvd_code_a: assert property ((route0_q[3:0] == 4'h8 && route1_q[3:0] == 4'h8)
                                |=> ctrl_irq_o[8] == $past(isa_s[8]))
    else $error("reserved code affected irq8");

  bus_mask_a: assert property ((!route0_q[7] && !route0_q[6] && route0_q[3:0] == 4'hA
                                && !board0_s && route1_q[3:0] != 4'hA) |=> !ctrl_irq_o[10])
    else $error("bus irq10 not masked");

  share_or_a: assert property ((!route0_q[7] && route0_q[6] && route0_q[3:0] == 4'h9
                                && isa_s[9]) |=> ctrl_irq_o[9])
    else $error("shared bus irq9 lost");

  timer_pin_a: assert property (timer_on_w |=> shared_timer_irq_pin_oe_o
                                && shared_timer_irq_pin_o == $past(timer_irq_i))
    else $error("timer output not driven on shared pin");

  disk_src_a: assert property (1'b1 |=> disk_irq_flag_o ==
                               ($past(timer_on_w) ? $past(isa_s[15]) : $past(pin_s)))
    else $error("disk flag from wrong source");

  // register port checks; the read data come from the register, so a read in
  // the same cycle as a write must still show the value from before the write
  route1_write_a: assert property (wr1_w |=> route1_q == ($past(cfg_wdata_i) & BIR_WMASK1))
    else $error("route 1 write not stored");

  rd_route0_a: assert property ((cfg_rd_i && cfg_addr_i == BIR_ROUTE0_OFS)
                                |=> cfg_rdata_o == $past(route0_q))
    else $error("route 0 read data wrong");

  rd_route1_a: assert property ((cfg_rd_i && cfg_addr_i == BIR_ROUTE1_OFS)
                                |=> cfg_rdata_o == $past(route1_q))
    else $error("route 1 read data wrong");

  rd_unmapped_a: assert property ((cfg_rd_i && cfg_addr_i != BIR_ROUTE0_OFS
                                  && cfg_addr_i != BIR_ROUTE1_OFS) |=> cfg_rdata_o == 8'h00)
    else $error("unmapped offset read nonzero");

  // software may sample the read data late, so it must hold between reads
  rd_hold_a: assert property (!cfg_rd_i |=> cfg_rdata_o == $past(cfg_rdata_o))
    else $error("read data changed without a read");

  // bits that are never stored must stay clear whatever software wrote
  rsvd_store_a: assert property (!route0_q[BIR_RSVD_BIT] && !route1_q[BIR_RSVD_BIT]
                                 && !route1_q[BIR_TIMER_BIT])
    else $error("reserved route bit stored");

  // shared pin direction; a late enable would fight the board device
  oe_follow_a: assert property (1'b1 |=> shared_timer_irq_pin_oe_o == $past(timer_on_w))
    else $error("pin enable does not follow option bit");

  pin_idle_a: assert property (!timer_on_w |=> !shared_timer_irq_pin_oe_o
                               && !shared_timer_irq_pin_o)
    else $error("shared pin driven while used as input");

  // with the pin as output and route 1 off, no board hit may reach the controller
  pin_loop_a: assert property ((timer_on_w && route1_q[BIR_DIS_BIT])
                               |=> (ctrl_irq_o & ~$past(isa_s)) == 16'h0000)
    else $error("timer output looped back as board request");

  // routing on the first route, independent of the second
  route0_hit_a: assert property ((!route0_q[7] && route0_q[3:0] == 4'h3 && board0_s)
                                 |=> ctrl_irq_o[3])
    else $error("board input 0 not routed to irq3");

  // a reserved code on route 1 must neither hit nor mask anything
  rsvd_code1_a: assert property ((route0_q[7] && !bir_target_ok(route1_q[3:0]))
                                 |=> ctrl_irq_o == $past(isa_s))
    else $error("reserved code on route 1 changed outputs");

  // sharing on route 1 keeps the board request visible
  share_or1_a: assert property ((!route1_q[7] && route1_q[6] && route1_q[3:0] == 4'hE
                                 && board1_s) |=> ctrl_irq_o[14])
    else $error("shared board irq14 lost");

  // masking on route 1; route 0 may not land a board hit on the same input
  bus_mask1_a: assert property ((!route1_q[7] && !route1_q[6] && route1_q[3:0] == 4'hC
                                 && !board1_s && !(route0_q[3:0] == 4'hC && !route0_q[7]
                                 && board0_s)) |=> !ctrl_irq_o[12])
    else $error("bus irq12 not masked");

  // a disabled route ignores the sharing bit, so the bus line passes through
  dis_pass_a: assert property ((route0_q[7] && route1_q[7] && isa_s[7])
                               |=> ctrl_irq_o[7])
    else $error("bus irq7 lost while routing disabled");

endmodule

//--- tb/bir_board_dev.sv
// bir_board_dev: board peripherals raising requests on the two board lines
// assumes: the bench sets the wanted levels, the model moves them after a clock edge
`timescale 1ns/10ps
module bir_board_dev (
  input  wire logic       clk_sys_i,  // system clock
  input  wire logic [1:0] req_i,      // levels wanted by the bench
  output logic      [1:0] line_o      // active-high level request lines
);
  // held as levels, never pulses, so a shared input cannot miss a request
  always_ff @(posedge clk_sys_i) begin
    line_o <= req_i;
  end
endmodule

//--- tb/tb.sv
// tb: random and corner-case checks of the board interrupt router
// assumes: bir_pkg and the router files are compiled first
`timescale 1ns/10ps
module tb;
  import bir_pkg::*;
  logic        clk_sys_i = 1'b0, reset_i = 1'b1, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
  logic        timer_irq_i = 1'b0, pin_o, pin_oe, disk_flag;
  logic [7:0]  cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, r0, r1, rd;
  logic [1:0]  req = 2'h0, line;
  logic [15:0] isa_irq_i = 16'h0000, ctrl_irq_o;
  logic [31:0] v0, v1;
  int          failures = 0, n_tests = 0, seed = 2;
  // the pin shows the router while it drives, the board device otherwise
  wire         pin_w = pin_oe ? pin_o : line[0];
  always #2 clk_sys_i = ~clk_sys_i;
  bir_board_dev dev_u (.clk_sys_i(clk_sys_i), .req_i(req), .line_o(line));
  bir_router dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .shared_timer_irq_pin_i(pin_w), .shared_timer_irq_pin_o(pin_o),
    .shared_timer_irq_pin_oe_o(pin_oe), .board_irq_in_i(line[1]), .isa_irq_i(isa_irq_i),
    .timer_irq_i(timer_irq_i), .ctrl_irq_o(ctrl_irq_o), .disk_irq_flag_o(disk_flag));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b0;
  endtask
  // read data is taken one edge after the strobe, once that edge has settled
  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    cfg_addr_i <= a;
    cfg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    cfg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 d = cfg_rdata_o;
  endtask
  // {hit, mask} of one route; reserved codes and disabled routes do nothing
  function automatic logic [31:0] route_vec(input logic [7:0] r, input logic b);
    logic ok;
    ok = !r[7] && !(r[3:0] inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hD});
    route_vec = 32'h0000_0000;
    if (ok) route_vec = {16'(b) << r[3:0], 16'(!r[6]) << r[3:0]};
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the roughly 760 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    cfg_read(8'h70, rd);
    check(16'(rd), 16'h0080);
    cfg_read(8'h71, rd);
    check(16'(rd), 16'h0080);
    cfg_read(8'h72, rd);
    check(16'(rd), 16'h0000);
    // codes 0..15 on route 1 first, then random settings; route 0 timer bit 5 always held clear
    for (int i = 0; i < 48; i++) begin
      r0 = 8'($random(seed)) & 8'hDF;
      r1 = (i < 16) ? {1'b0, 1'($random(seed)), 2'h3, 4'(i)} : 8'($random(seed));
      cfg_write(8'h70, r0);
      cfg_write(8'h71, r1);
      req <= 2'($random(seed));
      isa_irq_i <= 16'($random(seed));
      repeat (5) @(posedge clk_sys_i);
      #1 v0 = route_vec(r0, line[0]);
      v1 = route_vec(r1, line[1]);
      check(ctrl_irq_o, (isa_irq_i & ~(v0[15:0] | v1[15:0])) | v0[31:16] | v1[31:16]);
      check(16'(disk_flag), 16'(line[0]));
      check(16'({pin_oe, pin_o}), 16'h0000);
      cfg_read(8'h70, rd);
      check(16'(rd), 16'(r0 & 8'hEF));
      cfg_read(8'h71, rd);
      check(16'(rd), 16'(r1 & 8'hCF));
    end
    // timer option: pin becomes an output, disk flag follows input 15
    cfg_write(8'h70, 8'h25);
    for (int j = 0; j < 4; j++) begin
      timer_irq_i <= j[0];
      req <= 2'h1;
      isa_irq_i <= {j[1], 15'h0000};
      repeat (5) @(posedge clk_sys_i);
      #1 check({pin_oe, pin_o}, {1'b1, j[0]});
      check(16'(disk_flag), 16'(j[1]));
      check(ctrl_irq_o[5], 1'b0);
    end
    final_report();
  end
endmodule
